// file: verilog/erfs_map.svh
`ifndef ERFS_MAP_SVH
`define ERFS_MAP_SVH
// Function
// R1: Eleven filters, each individually enabled by software.
// R2: Fixed priority; first definitive verdict wins.
// R3: Collect forces accept; reject forces discard.
// R4: Frames never accepted are discarded, not stored.
// R5: Reset enables CRC-reject, short-reject, own-unicast, broadcast.
// R6: Control frames filtered only with pass option.
// R7: Host disables reception before changing filters.
// R8: Bit 15 enables hash-table hit acceptance.
// R9: Bit 14 enables wake-pattern acceptance.
// R10: Bit 12 inverts pattern checksum success condition.
// R11: Bits 11-8 pattern mode gate pattern acceptance.
// R12: Pattern mode codes decode; codes above 1001 reserved.
// R13: Bad-FCS accept or reject; others deferred.
// R14: Frames of 63 bytes or fewer are short.
// R15: Decrement control lowers count, self-clears immediately.
// R16: Status bit 15 pending; interrupt pin low if enabled.
// R17: Status bit 14 shows flow-control machine idle.
// R18: Status bit 13 high while frame is received.
// R19: Status bit 12 zero until clocks are stable.
// R20: Status bit 10 shows physical-layer full duplex.
// R21: Status bit 8 shows link established.
// R22: Status bits 7-0 hold pending packet count.
// R23: Reserved status bits ignored; filter bit 13 reads zero.
// R24: Count increments per accepted frame fully stored.

// Register byte addresses.
`define ERFS_ADDR_STATUS 12'h000
`define ERFS_ADDR_FILTER 12'h004
`define ERFS_ADDR_CONTROL 12'h008

// Status register fields.
`define ERFS_ST_IRQ 15
`define ERFS_ST_FC_IDLE 14
`define ERFS_ST_RX_ACTIVE 13
`define ERFS_ST_CLK_STABLE 12
`define ERFS_ST_DUPLEX 10
`define ERFS_ST_LINK 8

// Filter control register fields.
`define ERFS_FC_HASH 15
`define ERFS_FC_WAKE 14
`define ERFS_FC_UNUSED 13
`define ERFS_FC_INVERT 12
`define ERFS_FC_MODE_HI 11
`define ERFS_FC_MODE_LO 8
`define ERFS_FC_FCS_ACC 7
`define ERFS_FC_FCS_REJ 6
`define ERFS_FC_SHORT_ACC 5
`define ERFS_FC_SHORT_REJ 4
`define ERFS_FC_OWN 3
`define ERFS_FC_FOREIGN 2
`define ERFS_FC_GROUP 1
`define ERFS_FC_ALL 0
`define ERFS_FILTER_RESET 16'h0059
`define ERFS_FILTER_WMASK 16'hDFFF

// Control register fields.
`define ERFS_CT_RX_EN 0
`define ERFS_CT_PASS_CTL 1
`define ERFS_CT_GIE 2
`define ERFS_CT_PKT_DEC 8

// Largest short frame length in bytes.
`define ERFS_SHORT_MAX 16'h003F
`define ERFS_PKT_MAX 8'hFF
`endif

// file: verilog/erfs_pkg.sv
package erfs_pkg;

    typedef enum logic [3:0] {
        ERFS_PM_OFF = 4'h0,
        ERFS_PM_ANY = 4'h1,
        ERFS_PM_OWN = 4'h2,
        ERFS_PM_NOT_OWN = 4'h3,
        ERFS_PM_GROUP = 4'h4,
        ERFS_PM_NOT_GROUP = 4'h5,
        ERFS_PM_BCAST = 4'h6,
        ERFS_PM_NOT_BCAST = 4'h7,
        ERFS_PM_HASH = 4'h8,
        ERFS_PM_WAKE = 4'h9
    } erfs_pmode_t;

    typedef struct packed {
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [15:0] filt;
        logic rx_en;
        logic pass_ctl;
        logic gie;
        logic [7:0] pkt_cnt;
        logic rx_active;
        logic dec_valid;
        logic dec_accept;
        logic [31:0] rdata;
        logic slverr;
        logic irq_n;
    } erfs_state_t;

endpackage : erfs_pkg

// file: verilog/erfs_top.sv
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "erfs_map.svh"

module erfs_top
    import erfs_pkg::*;
(
    input wire logic pclk, // 200 MHz clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic frame_start, // Pulse: MAC begins taking a frame.
    input wire logic frame_end, // Pulse: frame complete, attributes valid.
    input wire logic frame_fcs_bad, // FCS of the frame is invalid.
    input wire logic [15:0] frame_length, // Frame length in bytes.
    input wire logic frame_is_control, // Frame is an Ethernet control frame.
    input wire logic dest_own, // Destination equals station_address.
    input wire logic dest_group, // Destination has the group bit set.
    input wire logic dest_bcast, // Destination is all ones.
    input wire logic hash_hit, // Hash detector selects a set table bit.
    input wire logic wake_hit, // Wake-up pattern detected.
    input wire logic pattern_csum_match, // Pattern checksum matches.
    output logic decision_valid, // Pulse: verdict for the last frame.
    output logic decision_accept, // Verdict: store the frame.
    input wire logic frame_stored, // Pulse: accepted frame fully written.
    input wire logic [15:0] irq_flags, // Interrupt flag register bits.
    input wire logic [15:0] irq_enables, // Interrupt enable register bits.
    input wire logic flow_ctrl_idle, // Flow-control machine is idle.
    input wire logic phy_link_up, // Pin: link established.
    input wire logic phy_full_duplex, // Pin: PHY in full duplex.
    input wire logic clocks_stable, // Pin: Ethernet clocks running stably.
    output logic receive_enable, // Reception enabled by software.
    output logic pass_control_frames, // Control frames go to the filters.
    output logic irq_n // Interrupt pin, active low.
);

    erfs_state_t q;
    erfs_state_t n;

    logic [15:0] status_w;
    logic [15:0] control_w;
    logic verdict;
    logic irq_pending;
    logic [1:0] acc_idx;

    function automatic logic [1:0] erfs_decode(input logic [11:0] addr);
        if (addr == `ERFS_ADDR_STATUS) begin
            erfs_decode = 2'd1;
        end else if (addr == `ERFS_ADDR_FILTER) begin
            erfs_decode = 2'd2;
        end else if (addr == `ERFS_ADDR_CONTROL) begin
            erfs_decode = 2'd3;
        end else begin
            erfs_decode = 2'd0;
        end
    endfunction : erfs_decode

    // Pattern mode condition; reserved codes never succeed.
    function automatic logic erfs_mode_cond(input logic [3:0] mode, input logic own,
                                            input logic grp, input logic bc,
                                            input logic hh, input logic wk);
        case (mode)
            ERFS_PM_ANY: erfs_mode_cond = 1'b1;
            ERFS_PM_OWN: erfs_mode_cond = own;
            ERFS_PM_NOT_OWN: erfs_mode_cond = !own;
            ERFS_PM_GROUP: erfs_mode_cond = grp;
            ERFS_PM_NOT_GROUP: erfs_mode_cond = !grp;
            ERFS_PM_BCAST: erfs_mode_cond = bc;
            ERFS_PM_NOT_BCAST: erfs_mode_cond = !bc;
            ERFS_PM_HASH: erfs_mode_cond = hh;
            ERFS_PM_WAKE: erfs_mode_cond = wk;
            default: erfs_mode_cond = 1'b0; // R12
        endcase
    endfunction : erfs_mode_cond

    // Filter chain; collection filters that may override rejections sit first.
    always_comb begin
        logic short_frame;
        logic pm_success;
        short_frame = 1'b0;
        pm_success = 1'b0;
        short_frame = (frame_length <= `ERFS_SHORT_MAX); // R14
        pm_success = q.filt[`ERFS_FC_INVERT] ? !pattern_csum_match
                                             : pattern_csum_match; // R10
        verdict = 1'b0; // R4
        if (q.filt[`ERFS_FC_FCS_ACC] && frame_fcs_bad) begin // R2 R13
            verdict = 1'b1; // R3
        end else if (q.filt[`ERFS_FC_SHORT_ACC] && short_frame) begin // R14
            verdict = 1'b1;
        end else if (q.filt[`ERFS_FC_FCS_REJ] && frame_fcs_bad) begin // R13
            verdict = 1'b0; // R3
        end else if (q.filt[`ERFS_FC_SHORT_REJ] && short_frame) begin // R14
            verdict = 1'b0;
        end else if (q.filt[`ERFS_FC_OWN] && dest_own) begin // R1
            verdict = 1'b1;
        end else if (q.filt[`ERFS_FC_FOREIGN] && !dest_group && !dest_own) begin
            verdict = 1'b1;
        end else if (q.filt[`ERFS_FC_GROUP] && dest_group) begin
            verdict = 1'b1;
        end else if (q.filt[`ERFS_FC_ALL] && dest_bcast) begin
            verdict = 1'b1;
        end else if (q.filt[`ERFS_FC_HASH] && hash_hit) begin // R8
            verdict = 1'b1;
        end else if (q.filt[`ERFS_FC_WAKE] && wake_hit) begin // R9
            verdict = 1'b1;
        end else if (pm_success && erfs_mode_cond(q.filt[`ERFS_FC_MODE_HI:`ERFS_FC_MODE_LO],
                     dest_own, dest_group, dest_bcast, hash_hit, wake_hit)) begin // R11
            verdict = 1'b1;
        end
        // The MAC keeps control frames to itself unless software asks for them.
        if (frame_is_control && !q.pass_ctl) begin // R6
            verdict = 1'b0;
        end
        if (!q.rx_en) begin
            verdict = 1'b0;
        end
    end

    assign irq_pending = |(irq_flags & irq_enables); // R16

    always_comb begin
        status_w = 16'h0000;
        status_w[`ERFS_ST_IRQ] = irq_pending; // R16
        status_w[`ERFS_ST_FC_IDLE] = flow_ctrl_idle; // R17
        status_w[`ERFS_ST_RX_ACTIVE] = q.rx_active; // R18
        status_w[`ERFS_ST_CLK_STABLE] = q.sync_b[2]; // R19
        status_w[`ERFS_ST_DUPLEX] = q.sync_b[1]; // R20
        status_w[`ERFS_ST_LINK] = q.sync_b[0]; // R21
        status_w[7:0] = q.pkt_cnt; // R22
        control_w = 16'h0000;
        control_w[`ERFS_CT_RX_EN] = q.rx_en;
        control_w[`ERFS_CT_PASS_CTL] = q.pass_ctl;
        control_w[`ERFS_CT_GIE] = q.gie;
    end

    always_comb begin
        logic do_write;
        logic pkt_inc;
        logic pkt_dec;
        do_write = 1'b0;
        pkt_inc = 1'b0;
        pkt_dec = 1'b0;
        n = q;
        acc_idx = erfs_decode(paddr);
        // The first stage feeds only the second; nothing else looks at it.
        n.sync_a = {clocks_stable, phy_full_duplex, phy_link_up};
        n.sync_b = q.sync_a;

        // Read data and error are captured in setup, so access needs no wait.
        if (psel && !penable) begin
            n.slverr = (acc_idx == 2'd0);
            if (acc_idx == 2'd1) begin
                n.rdata = {16'h0000, status_w};
            end else if (acc_idx == 2'd2) begin
                n.rdata = {16'h0000, q.filt};
            end else if (acc_idx == 2'd3) begin
                n.rdata = {16'h0000, control_w};
            end else begin
                n.rdata = 32'h0000_0000;
            end
        end
        do_write = psel && penable && pwrite;
        if (do_write && acc_idx == 2'd2) begin
            n.filt = pwdata[15:0] & `ERFS_FILTER_WMASK; // R1 R23
        end
        if (do_write && acc_idx == 2'd3) begin
            n.rx_en = pwdata[`ERFS_CT_RX_EN];
            n.pass_ctl = pwdata[`ERFS_CT_PASS_CTL];
            n.gie = pwdata[`ERFS_CT_GIE];
            // The decrement bit is never stored, so it always reads back zero.
            pkt_dec = pwdata[`ERFS_CT_PKT_DEC]; // R15
        end

        // A frame is tracked only if reception is on when it starts.
        if (frame_start && q.rx_en) begin
            n.rx_active = 1'b1; // R18
        end else if (frame_end) begin
            n.rx_active = 1'b0;
        end
        n.dec_valid = frame_end && q.rx_active;
        n.dec_accept = frame_end && q.rx_active && verdict; // R4

        // An increment and a decrement in one cycle cancel; the count holds at ERFS_PKT_MAX and at zero.
        pkt_inc = frame_stored; // R24
        if (pkt_inc && !pkt_dec) begin
            if (q.pkt_cnt != `ERFS_PKT_MAX) begin
                n.pkt_cnt = q.pkt_cnt + 8'h01;
            end
        end else if (pkt_dec && !pkt_inc) begin
            if (q.pkt_cnt != 8'h00) begin
                n.pkt_cnt = q.pkt_cnt - 8'h01; // R22
            end
        end
        n.irq_n = !(irq_pending && q.gie); // R16
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.filt <= `ERFS_FILTER_RESET; // R5
            q.irq_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign prdata = q.rdata;
    assign pready = 1'b1;
    assign pslverr = q.slverr && psel && penable;
    assign decision_valid = q.dec_valid;
    assign decision_accept = q.dec_accept;
    assign receive_enable = q.rx_en;
    assign pass_control_frames = q.pass_ctl;
    assign irq_n = q.irq_n;

endmodule : erfs_top

// file: testbench/erfs_asserts.sv
`timescale 1ns/1ps
module erfs_asserts (
    input wire logic pclk, // Clock.
    input wire logic presetn, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Access phase.
    input wire logic pwrite, // Direction.
    input wire logic [11:0] paddr, // Address.
    input wire logic pslverr, // Error.
    input wire logic frame_end, // Frame done.
    input wire logic decision_valid, // Verdict strobe.
    input wire logic decision_accept, // Verdict.
    input wire logic receive_enable, // Reception on.
    input wire logic [15:0] irq_flags, // Flags.
    input wire logic [15:0] irq_enables, // Enables.
    input wire logic irq_n // Interrupt pin.
);
    wire logic cause = |(irq_flags & irq_enables);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_verdict_one_cycle: assert property (decision_valid |=> !decision_valid)
        else $error("verdict strobe held too long");
    a_verdict_after_end: assert property (decision_valid |-> $past(frame_end))
        else $error("verdict without frame end");
    a_accept_needs_rx: assert property (
        decision_valid && decision_accept |-> $past(receive_enable))
        else $error("accept while reception off");
    a_irq_low_cause: assert property (!irq_n |-> $past(cause))
        else $error("interrupt pin low without cause");
    a_irq_high_idle: assert property (!cause |=> irq_n)
        else $error("interrupt pin low after cause gone");
    a_rx_by_write: assert property (
        $changed(receive_enable) |-> $past(psel) && $past(penable) && $past(pwrite))
        else $error("reception changed without a write");
    a_mapped_no_err: assert property (
        psel && penable && paddr inside {12'h000, 12'h004, 12'h008} |-> !pslverr)
        else $error("error on mapped register");
    a_unmapped_err: assert property (psel && penable && paddr > 12'h008 |-> pslverr)
        else $error("no error on unmapped address");
endmodule : erfs_asserts

bind erfs_top erfs_asserts u_erfs_asserts (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pslverr, .frame_end, .decision_valid, .decision_accept, .receive_enable,
    .irq_flags, .irq_enables, .irq_n);

// file: testbench/erfs_mac_model.sv
`timescale 1ns/1ps
module erfs_mac_model (
    input wire logic pclk, // Clock.
    input wire logic decision_valid, // Verdict strobe.
    input wire logic decision_accept, // Verdict.
    output logic frame_start = 1'b0, // Frame begins.
    output logic frame_end = 1'b0, // Frame done.
    output logic [23:0] attr = 24'h00_0000, // Frame attributes.
    output logic frame_stored = 1'b0 // Accepted frame written.
);
    always @(posedge pclk) frame_stored <= decision_valid && decision_accept;
    // Attributes mean nothing outside frame_end, so they show the inverse there.
    task automatic send(input logic [23:0] a, input int len);
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        repeat (len) @(posedge pclk);
        frame_end <= 1'b1;
        attr <= a;
        @(posedge pclk);
        frame_end <= 1'b0;
        attr <= ~a;
    endtask : send
endmodule : erfs_mac_model

// file: testbench/erfs_bench.sv
`timescale 1ns/1ps
module erfs_bench;
    logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rv;
    logic frame_start, frame_end, frame_fcs_bad, frame_is_control, dest_own, dest_group;
    logic dest_bcast, hash_hit, wake_hit, pattern_csum_match, decision_valid, decision_accept;
    logic [15:0] frame_length, irq_flags = 16'h0000, irq_enables = 16'h0000;
    logic [23:0] attr;
    logic frame_stored, flow_ctrl_idle = 1'b1, phy_link_up = 1'b0, phy_full_duplex = 1'b1;
    logic clocks_stable = 1'b1, receive_enable, pass_control_frames, irq_n, err;
    logic [7:0] cnt = 8'h00;
    logic [15:0] vec = 16'h03A6;
    int fails = 0, num_checks = 0;
    assign {frame_fcs_bad, frame_length, frame_is_control, dest_own, dest_group, dest_bcast,
        hash_hit, wake_hit, pattern_csum_match} = attr;
    erfs_top u_erfs_top (.*);
    erfs_mac_model u_erfs_mac_model (.*);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // An idle cycle follows each transfer so no strobe is assigned twice in one step.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic fcase(input logic [15:0] f, input logic [23:0] a, input logic ex,
        input logic pc);
        apb(1'b1, 12'h008, 32'h0000_0000);
        apb(1'b1, 12'h004, {16'h0000, f});
        apb(1'b1, 12'h008, {30'h0000_0000, pc, 1'b1});
        chk("receive_enable", receive_enable, 32'h0000_0001);
        chk("pass_control_frames", pass_control_frames, {31'h0000_0000, pc});
        u_erfs_mac_model.send(a, 3);
        @(negedge pclk);
        chk("decision_valid", decision_valid, 32'h0000_0001);
        chk("decision_accept", decision_accept, {31'h0000_0000, ex});
        cnt = cnt + ex;
        // The store pulse lands one edge after the verdict and the count one edge later, so let the count settle.
        // This also puts the next bus request back on a rising edge.
        repeat (2) @(posedge pclk);
    endtask : fcase
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("filter_reset", rv, 32'h0000_0059);
        apb(1'b1, 12'h004, 32'h0000_FFFF);
        apb(1'b0, 12'h004, 32'h0000_0000);
        chk("filter_mask", rv, 32'h0000_DFFF);
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk("unmapped_err", err, 32'h0000_0001);
        fcase(16'h0059, {1'b1, 16'h0064, 7'h20}, 1'b0, 1'b0);
        fcase(16'h0059, {1'b0, 16'h003F, 7'h20}, 1'b0, 1'b0);
        fcase(16'h0059, {1'b0, 16'h0040, 7'h20}, 1'b1, 1'b0);
        fcase(16'h0059, {1'b0, 16'h0040, 7'h00}, 1'b0, 1'b0);
        fcase(16'h00D9, {1'b1, 16'h0040, 7'h00}, 1'b1, 1'b0);
        fcase(16'h0030, {1'b0, 16'h003F, 7'h00}, 1'b1, 1'b0);
        fcase(16'h0004, {1'b0, 16'h0040, 7'h00}, 1'b1, 1'b0);
        fcase(16'h0004, {1'b0, 16'h0040, 7'h10}, 1'b0, 1'b0);
        fcase(16'h0002, {1'b0, 16'h0040, 7'h10}, 1'b1, 1'b0);
        fcase(16'h0001, {1'b0, 16'h0040, 7'h18}, 1'b1, 1'b0);
        fcase(16'h8000, {1'b0, 16'h0040, 7'h04}, 1'b1, 1'b0);
        fcase(16'h4000, {1'b0, 16'h0040, 7'h02}, 1'b1, 1'b0);
        fcase(16'h0059, {1'b0, 16'h0040, 7'h60}, 1'b0, 1'b0);
        fcase(16'h0059, {1'b0, 16'h0040, 7'h60}, 1'b1, 1'b1);
        fcase(16'h1100, {1'b0, 16'h0040, 7'h20}, 1'b1, 1'b0);
        for (int i = 0; i < 32; i++) begin
            fcase({3'h0, i[4:0], 8'h00}, {1'b0, 16'h0040, 7'h27}, !i[4] && vec[i[3:0]], 1'b0);
        end
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("status", rv, {16'h0000, 8'h54, cnt});
        phy_link_up <= 1'b1;
        phy_full_duplex <= 1'b0;
        apb(1'b1, 12'h008, 32'h0000_0100);
        apb(1'b1, 12'h008, 32'h0000_0100);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk("decrement_self_clear", rv, 32'h0000_0000);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("status_after_dec", rv, {16'h0000, 8'h51, cnt - 8'h02});
        irq_flags <= 16'h0001;
        irq_enables <= 16'h0001;
        apb(1'b1, 12'h008, 32'h0000_0004);
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("irq_pending", rv[15], 32'h0000_0001);
        chk("irq_n_low", irq_n, 32'h0000_0000);
        irq_enables <= 16'h0000;
        repeat (3) @(posedge pclk);
        chk("irq_n_high", irq_n, 32'h0000_0001);
        apb(1'b1, 12'h008, 32'h0000_0001);
        fork
            u_erfs_mac_model.send({1'b0, 16'h0040, 7'h20}, 12);
            begin
                repeat (2) @(posedge pclk);
                apb(1'b0, 12'h000, 32'h0000_0000);
                chk("receive_active", rv[13], 32'h0000_0001);
            end
        join
        apb(1'b0, 12'h000, 32'h0000_0000);
        chk("receive_idle", rv[13], 32'h0000_0000);
        apb(1'b1, 12'h008, 32'h0000_0000);
        u_erfs_mac_model.send({1'b0, 16'h0040, 7'h20}, 3);
        @(negedge pclk);
        chk("ignored_when_off", decision_valid, 32'h0000_0000);
        tally_and_finish();
    end
endmodule : erfs_bench
